// ---- hw/fwd_mode_pkg.sv ----
// Constants for the forward-channel mode selection registers.
// Assumes a byte-wide register port with 8-bit offsets.
package fwd_mode_pkg;
    localparam logic [7:0] addr_forward_mode_select = 8'h03;
    localparam logic [7:0] addr_backcompat_mode_select = 8'h04;
    localparam int mode_lsb = 0;
    localparam int mode_done_bit = 3;
    localparam int mode_override_bit = 4;
    localparam int res5_bit = 5;
    localparam int strap6_bit = 6;
    localparam int res7_bit = 7;
    localparam int autoload_inhibit_bit = 0;
    localparam int raw12_bit = 1;
    localparam int raw10_bit = 2;
    localparam int bc_res_lsb = 3;
    localparam logic [2:0] mode_csi_sync = 3'h0;
    localparam logic [2:0] mode_reserved = 3'h1;
    localparam logic [2:0] mode_csi_ext_clk = 3'h2;
    localparam logic [2:0] mode_csi_int_clk = 3'h3;
    localparam logic [2:0] mode_parallel_video_port = 3'h5;
    localparam logic [4:0] bc_res_reset = 5'h00;
    localparam logic [2:0] mode_reset = 3'h0;
    localparam int settle_cycles = 4;
    localparam logic [2:0] settle_max = 3'h4;
    typedef enum logic [2:0] {
        op_csi_sync, op_csi_ext_clk, op_csi_int_clk, op_parallel, op_unsupported
    } op_mode_t;
endpackage : fwd_mode_pkg

// ---- hw/mode_strap_sync.sv ----
// Two-flop synchroniser for the strap and power-down pins.
// Assumes all four pins (three strap, one power-down) are asynchronous to clock_i.
`timescale 1ns/1ps
module mode_strap_sync (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [3:0] async_i,
    output logic [3:0] sync_o
);
    logic [3:0] meta;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= 4'h0;
            sync_o <= 4'h0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule : mode_strap_sync

// ---- hw/forward_mode_select_regs.sv ----
// Mode select and backward-compatible sub-mode registers.
// Assumes a simple synchronous byte register port and an on-chip control channel.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Mode in effect comes from strap when override bit 4 clear, else register.
// [RULE_02] Mode field bits 2:0 read-only unless override set, then writable.
// [RULE_03] Reading mode field returns the mode currently in effect.
// [RULE_04] Strapped mode captured on each rising edge of power-down input.
// [RULE_05] Mode-done flag bit 3, read-only, resets 0, sets once mode settled.
// [RULE_06] Code 000 is camera-serial synchronous; 001 is reserved.
// [RULE_07] 010 non-synchronous external clock; 011 non-synchronous always-on clock.
// [RULE_08] Code 101 is parallel video port mode on external clock.
// [RULE_09] Control channel sets RAW10 compat bit 2 after lock; software may write.
// [RULE_10] Control channel sets RAW12 compat bit 1 after lock; software may write.
// [RULE_11] Inhibit bit 0 blocks control-channel loading of compat bits.
// [RULE_12] Software writing compat bits must also set inhibit bit.
// [RULE_13] Codes 100, 110, 111 select no defined operating mode.
module forward_mode_select_regs (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [2:0] mode_strap_i,
    input wire logic power_down_input_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic rx_lock_i,
    input wire logic cc_load_i,
    input wire logic cc_raw10_i,
    input wire logic cc_raw12_i,
    output logic [2:0] mode_o,
    output fwd_mode_pkg::op_mode_t op_mode_o,
    output logic mode_done_o,
    output logic raw10_compat_bit_o,
    output logic raw12_compat_bit_o
);
    logic [3:0] pin_sync;
    logic pd_pin_d;
    logic [2:0] strap_mode;
    logic [2:0] reg_mode;
    logic mode_override;
    logic res5;
    logic res7;
    logic [2:0] settle_cnt;
    logic mode_done;
    logic [4:0] bc_res;
    logic raw10_compat_bit;
    logic raw12_compat_bit;
    logic compat_autoload_inhibit;
    logic [2:0] next_mode;
    logic wr_fms;
    logic wr_bcm;
    logic pd_rise;
    fwd_mode_pkg::op_mode_t next_op;

    // Pins are asynchronous, so sample them twice first
    mode_strap_sync u_sync (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .async_i({power_down_input_i, mode_strap_i}),
        .sync_o(pin_sync)
    );

    assign pd_rise = pin_sync[3] && !pd_pin_d;
    assign wr_fms = reg_wr_i && (reg_addr_i == fwd_mode_pkg::addr_forward_mode_select);
    assign wr_bcm = reg_wr_i && (reg_addr_i == fwd_mode_pkg::addr_backcompat_mode_select);
    assign next_mode = mode_override ? reg_mode : strap_mode; // RULE_01

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pd_pin_d <= 1'b0;
        end else begin
            pd_pin_d <= pin_sync[3];
        end
    end

    // Strap latched on power-down release only
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_mode <= fwd_mode_pkg::mode_reset;
        end else if (pd_rise) begin
            strap_mode <= pin_sync[2:0]; // RULE_04
        end
    end

    // Settle counter restarts on every release
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            settle_cnt <= 3'h0;
            mode_done <= 1'b0;
        end else if (pd_rise) begin
            settle_cnt <= 3'h0;
            mode_done <= 1'b0;
        end else if (pd_pin_d && !mode_done) begin
            if (settle_cnt == fwd_mode_pkg::settle_max) begin
                mode_done <= 1'b1; // RULE_05
            end else begin
                settle_cnt <= settle_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_override <= 1'b0;
            res5 <= 1'b0;
            res7 <= 1'b0;
            reg_mode <= fwd_mode_pkg::mode_reset;
        end else if (wr_fms) begin
            mode_override <= reg_wdata_i[fwd_mode_pkg::mode_override_bit];
            res5 <= reg_wdata_i[fwd_mode_pkg::res5_bit];
            res7 <= reg_wdata_i[fwd_mode_pkg::res7_bit];
            if (mode_override) begin
                reg_mode <= reg_wdata_i[fwd_mode_pkg::mode_lsb +: 3]; // RULE_02
            end else begin
                // Preload so setting override alone keeps the strapped mode
                reg_mode <= strap_mode;
            end
        end
    end

    // Set by channel wins over software when both hit one cycle
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bc_res <= fwd_mode_pkg::bc_res_reset;
            raw10_compat_bit <= 1'b0;
            raw12_compat_bit <= 1'b0;
            compat_autoload_inhibit <= 1'b0;
        end else begin
            if (wr_bcm) begin
                bc_res <= reg_wdata_i[fwd_mode_pkg::bc_res_lsb +: 5];
                raw10_compat_bit <= reg_wdata_i[fwd_mode_pkg::raw10_bit];
                raw12_compat_bit <= reg_wdata_i[fwd_mode_pkg::raw12_bit];
                compat_autoload_inhibit <= reg_wdata_i[fwd_mode_pkg::autoload_inhibit_bit];
            end
            if (cc_load_i && rx_lock_i && !compat_autoload_inhibit) begin // RULE_11
                raw10_compat_bit <= cc_raw10_i; // RULE_09
                raw12_compat_bit <= cc_raw12_i; // RULE_10
            end
        end
    end

    always_comb begin
        unique case (next_mode)
            fwd_mode_pkg::mode_csi_sync: next_op = fwd_mode_pkg::op_csi_sync; // RULE_06
            fwd_mode_pkg::mode_csi_ext_clk: next_op = fwd_mode_pkg::op_csi_ext_clk; // RULE_07
            fwd_mode_pkg::mode_csi_int_clk: next_op = fwd_mode_pkg::op_csi_int_clk; // RULE_07
            fwd_mode_pkg::mode_parallel_video_port: next_op = fwd_mode_pkg::op_parallel; // RULE_08
            default: next_op = fwd_mode_pkg::op_unsupported; // RULE_13
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_o <= fwd_mode_pkg::mode_reset;
            op_mode_o <= fwd_mode_pkg::op_csi_sync;
            mode_done_o <= 1'b0;
            raw10_compat_bit_o <= 1'b0;
            raw12_compat_bit_o <= 1'b0;
        end else begin
            mode_o <= next_mode;
            op_mode_o <= next_op;
            mode_done_o <= mode_done;
            raw10_compat_bit_o <= raw10_compat_bit;
            raw12_compat_bit_o <= raw12_compat_bit;
        end
    end

    // Read data registered: answer one cycle after the strobe
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            if (reg_addr_i == fwd_mode_pkg::addr_forward_mode_select) begin
                reg_rdata_o <= {res7, 1'b0, res5, mode_override, mode_done, next_mode}; // RULE_03
            end else if (reg_addr_i == fwd_mode_pkg::addr_backcompat_mode_select) begin
                reg_rdata_o <= {bc_res, raw10_compat_bit, raw12_compat_bit,
                    compat_autoload_inhibit};
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

    a_mode_source: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_01
        !mode_override |=> (mode_o == $past(strap_mode)))
        else $error("mode output not from strap");
    a_ro_mode: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_02
        (wr_fms && !mode_override) |=> (reg_mode == $past(strap_mode)))
        else $error("mode field written while locked");
    a_mode_write: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_02
        (wr_fms && mode_override)
        |=> (reg_mode == $past(reg_wdata_i[fwd_mode_pkg::mode_lsb +: 3])))
        else $error("mode field write lost");
    a_strap_latch: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_04
        pd_rise |=> (strap_mode == $past(pin_sync[2:0])))
        else $error("strap not captured on release");
    a_done_clear: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_05
        pd_rise |=> !mode_done [*3])
        else $error("mode done set too early");
    a_done_set: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_05
        (pd_rise ##1 pin_sync[3] [*7]) |=> mode_done)
        else $error("mode done never set");
    a_done_hold: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_05
        (mode_done && !pd_rise) |=> mode_done)
        else $error("mode done dropped without release");
    a_unsupported: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_13
        (next_mode == 3'h4 || next_mode >= 3'h6 || next_mode == fwd_mode_pkg::mode_reserved)
        |=> op_mode_o == fwd_mode_pkg::op_unsupported)
        else $error("undefined code entered a mode");
    a_parallel: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_08
        (next_mode == fwd_mode_pkg::mode_parallel_video_port)
        |=> op_mode_o == fwd_mode_pkg::op_parallel)
        else $error("parallel mode not decoded");
    a_inhibit: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_11
        (compat_autoload_inhibit && !wr_bcm) |=> $stable(raw10_compat_bit)
        && $stable(raw12_compat_bit))
        else $error("compat bits loaded while inhibited");
    a_autoload: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_09 RULE_10
        (cc_load_i && rx_lock_i && !compat_autoload_inhibit)
        |=> raw10_compat_bit == $past(cc_raw10_i) && raw12_compat_bit == $past(cc_raw12_i))
        else $error("channel load lost");
endmodule : forward_mode_select_regs

// ---- bench/cc_partner.sv ----
// Remote receiver control channel: lock level and load pulses.
// Assumes the bench clock; drives 2 ns after a rising edge.
`timescale 1ns/1ps
module cc_partner (
    input wire logic clock_i,
    output logic rx_lock_o,
    output logic cc_load_o,
    output logic cc_raw10_o,
    output logic cc_raw12_o
);
    initial begin
        rx_lock_o = 1'b0;
        cc_load_o = 1'b0;
        cc_raw10_o = 1'b0;
        cc_raw12_o = 1'b1;
    end
    task automatic send(input logic lock, input logic r10, input logic r12);
        @(posedge clock_i);
        #2;
        rx_lock_o = lock;
        cc_load_o = 1'b1;
        cc_raw10_o = r10;
        cc_raw12_o = r12;
        @(posedge clock_i);
        #2;
        cc_load_o = 1'b0;
        // Flip released lines so a late sample cannot match by luck
        cc_raw10_o = ~r10;
        cc_raw12_o = ~r12;
    endtask : send
endmodule : cc_partner

// ---- bench/forward_mode_select_regs_test.sv ----
// Self-checking bench for the mode select registers.
// Assumes cc_partner stands in for the control channel; 40 MHz clock.
`timescale 1ns/1ps
module forward_mode_select_regs_test;
    logic clock_i, nrst_i, pd_i, reg_wr_i, reg_rd_i, mode_done_o, r10_o, r12_o;
    logic lock, load, c10, c12;
    logic [2:0] strap, mode_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    fwd_mode_pkg::op_mode_t op_mode_o;
    int fails = 0;
    int comparisons = 0;
    forward_mode_select_regs uut (.clock_i(clock_i), .nrst_i(nrst_i), .mode_strap_i(strap),
        .power_down_input_i(pd_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .rx_lock_i(lock), .cc_load_i(load), .cc_raw10_i(c10), .cc_raw12_i(c12),
        .mode_o(mode_o), .op_mode_o(op_mode_o), .mode_done_o(mode_done_o),
        .raw10_compat_bit_o(r10_o), .raw12_compat_bit_o(r12_o));
    cc_partner cc (.clock_i(clock_i), .rx_lock_o(lock), .cc_load_o(load),
        .cc_raw10_o(c10), .cc_raw12_o(c12));
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic check8(input string what, input logic [7:0] want, input logic [7:0] got);
        comparisons++;
        if (got !== want) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, want, got);
        end
    endtask : check8
    task automatic check_op(input logic [2:0] m);
        fwd_mode_pkg::op_mode_t want;
        case (m)
            3'h0: want = fwd_mode_pkg::op_csi_sync;
            3'h2: want = fwd_mode_pkg::op_csi_ext_clk;
            3'h3: want = fwd_mode_pkg::op_csi_int_clk;
            3'h5: want = fwd_mode_pkg::op_parallel;
            default: want = fwd_mode_pkg::op_unsupported;
        endcase
        comparisons++;
        if (op_mode_o !== want) begin
            fails++;
            $display("[ERR] op_mode_o expected %0d seen %0d", want, op_mode_o);
        end
    endtask : check_op
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #2;
        reg_wr_i = w;
        reg_rd_i = ~w;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge clock_i);
        #2;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
    endtask : access
    task automatic rd(input string what, input logic [7:0] a, input logic [7:0] want);
        access(1'b0, a, 8'h00);
        check8(what, want, reg_rdata_o);
    endtask : rd
    // Pin low long enough to pass the synchroniser, then rise
    task automatic strap_cycle(input logic [2:0] s);
        int n;
        pd_i = 1'b0;
        strap = s;
        repeat (6) @(posedge clock_i);
        #2;
        pd_i = 1'b1;
        repeat (4) @(posedge clock_i);
        #2;
        check8("done early", 8'h00, {7'h00, mode_done_o});
        n = 0;
        while (mode_done_o !== 1'b1 && n < 30) begin
            @(posedge clock_i);
            n++;
        end
        #2;
        check8("done", 8'h01, {7'h00, mode_done_o});
    endtask : strap_cycle
    task automatic t_reset();
        check8("done reset", 8'h00, {7'h00, mode_done_o});
        rd("compat reset", 8'h04, 8'h00);
        rd("unmapped", 8'h05, 8'h00);
    endtask : t_reset
    task automatic t_strap();
        strap_cycle(3'h2);
        rd("strap 2", 8'h03, 8'h0a);
        check_op(3'h2);
        strap = 3'h5;
        repeat (8) @(posedge clock_i);
        rd("no edge", 8'h03, 8'h0a);
        access(1'b1, 8'h03, 8'h07);
        rd("ro mode", 8'h03, 8'h0a);
        strap_cycle(3'h5);
        rd("strap 5", 8'h03, 8'h0d);
        check8("mode_o", 8'h05, {5'h00, mode_o});
        check_op(3'h5);
    endtask : t_strap
    task automatic t_override();
        access(1'b1, 8'h03, 8'h10);
        for (int m = 0; m < 8; m++) begin
            access(1'b1, 8'h03, 8'h10 | 8'(m));
            rd("override", 8'h03, 8'h18 | 8'(m));
            check_op(3'(m));
        end
        access(1'b1, 8'h03, 8'he0);
        rd("back to strap", 8'h03, 8'had);
        check8("mode_o strap", 8'h05, {5'h00, mode_o});
    endtask : t_override
    task automatic t_compat();
        cc.send(1'b0, 1'b1, 1'b1);
        rd("no lock", 8'h04, 8'h00);
        cc.send(1'b1, 1'b1, 1'b0);
        rd("load 10", 8'h04, 8'h04);
        check8("raw10 out", 8'h01, {7'h00, r10_o});
        cc.send(1'b1, 1'b0, 1'b1);
        rd("load 12", 8'h04, 8'h02);
        check8("raw12 out", 8'h01, {7'h00, r12_o});
        access(1'b1, 8'h04, 8'hf9);
        cc.send(1'b1, 1'b1, 1'b1);
        rd("inhibit", 8'h04, 8'hf9);
        access(1'b1, 8'h04, 8'h05);
        rd("sw write", 8'h04, 8'h05);
        check8("raw bits", 8'h02, {6'h00, r10_o, r12_o});
    endtask : t_compat
    initial begin
        nrst_i = 1'b0;
        pd_i = 1'b0;
        strap = 3'h0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        repeat (16) @(posedge clock_i);
        #2;
        nrst_i = 1'b1;
        t_reset();
        t_strap();
        t_override();
        t_compat();
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge clock_i);
        fails++;
        finish_test();
    end
endmodule : forward_mode_select_regs_test
